// ===== design/ddp_pkg.sv
// constants, field layouts and carrier types of the download descriptor parser
// ============================================================================
// Contract
// - descriptors are accepted from both DII and DSI loops as optional extensions
// - tag 0xb8 is a group-chaining descriptor valid only in DSI group info
// - tag 0xb4 in the DII per-module loop decodes as module chaining
// - module chain ordering is reported for downstream reassembly
// - byte after each tag counts the bytes left and locates the descriptor end
// - module chain place 0x00 first, 0x01 intermediate, 0x02 last
// - 16-bit next module ident follows place and is disregarded when last
// - tag 0xb5 decodes as the whole-module checksum descriptor
// - the 32-bit whole-module crc is presented for comparison with a computed one
// - whole-module crc may coexist with per-section crcs; neither is required absent
// - group chaining identifies group descriptions linked into one larger group
// - group chain place 0x00 first, 0x01 intermediate, 0x02 last
// - 32-bit next group ident follows place and is ignored when last
// - no dependence on group link order; absence of group chaining is fine
// - the per-module loop is bounded by its 8-bit length, 0 to 255 bytes
package ddp_pkg;

  // ==========================================================================
  // descriptor tags and chain places
  localparam logic [7:0] TAG_MODULE_CHAIN = 8'hb4;
  localparam logic [7:0] TAG_WHOLE_CRC = 8'hb5;
  localparam logic [7:0] TAG_GROUP_CHAIN = 8'hb8;
  localparam logic [7:0] PLACE_FIRST = 8'h00;
  localparam logic [7:0] PLACE_MIDDLE = 8'h01;
  localparam logic [7:0] PLACE_LAST = 8'h02;

  // least body lengths that carry every field
  localparam logic [7:0] MOD_CHAIN_BODY_LEN = 8'h03;
  localparam logic [7:0] WHOLE_CRC_BODY_LEN = 8'h04;
  localparam logic [7:0] GROUP_CHAIN_BODY_LEN = 8'h05;

  // ==========================================================================
  // crc engine
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;

  // ==========================================================================
  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MOD_CHAIN = 8'h08;
  localparam logic [7:0] ADDR_GROUP_PLACE = 8'h0c;
  localparam logic [7:0] ADDR_GROUP_NEXT = 8'h10;
  localparam logic [7:0] ADDR_CRC_EXPECT = 8'h14;
  localparam logic [7:0] ADDR_CRC_COMPUTED = 8'h18;
  localparam logic [7:0] ADDR_COUNTS = 8'h1c;

  // control fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 8;
  localparam logic CTRL_ENABLE_RESET = 1'b1;

  // status fields
  localparam int ST_CRC_DONE_BIT = 2;
  localparam int ST_CRC_MATCH_BIT = 3;
  localparam int ST_MOD_SEEN_BIT = 4;
  localparam int ST_GROUP_SEEN_BIT = 5;
  localparam int ST_CRC_SEEN_BIT = 6;

  localparam logic [1:0] AXI_RESP_OKAY = 2'b00;

  // ==========================================================================
  // parser states
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_TAG = 2'b01,
    S_LEN = 2'b10,
    S_BODY = 2'b11
  } parse_state_t;

  // ==========================================================================
  // report carriers
  typedef struct packed {
    logic valid;
    logic [7:0] place;
    logic nextValid;
    logic [15:0] nextModuleIdent;
  } mod_chain_t;

  typedef struct packed {
    logic valid;
    logic [7:0] place;
    logic nextValid;
    logic [31:0] nextGroupIdent;
  } group_chain_t;

  typedef struct packed {
    logic valid;
    logic [31:0] crc;
  } crc_desc_t;

endpackage : ddp_pkg

// ===== design/crc32_byte_engine.sv
// crc-32 engine that folds one byte per accepted cycle, msb first
`timescale 1ns/1ps
`default_nettype none
module crc32_byte_engine (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic restart,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  output logic [31:0] crcValue
);

  logic [31:0] crc_r;
  logic [31:0] crc_nxt;

  // ==========================================================================
  // bitwise fold of one byte; no reflection and no final inversion
  always_comb begin
    logic fb;
    crc_nxt = crc_r;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = crc_nxt[31] ^ byteData[i];
      crc_nxt = {crc_nxt[30:0], 1'b0} ^ (fb ? ddp_pkg::CRC_POLY : 32'h00000000);
    end
  end

  // restart takes priority so a new module never inherits the old remainder
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      crc_r <= ddp_pkg::CRC_INIT;
    end else if (restart) begin
      crc_r <= ddp_pkg::CRC_INIT;
    end else if (byteValid) begin
      crc_r <= crc_nxt;
    end
  end

  assign crcValue = crc_r;

endmodule : crc32_byte_engine
`default_nettype wire

// ===== design/download_descriptor_parser.sv
// descriptor parser for download control messages with an axi4-lite register port
`timescale 1ns/1ps
`default_nettype none
module download_descriptor_parser (
  input wire logic mclk,
  input wire logic rstn,
  // axi4-lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // loop announcement from the section filter
  input wire logic loopStart,
  input wire logic [7:0] loopLen,
  input wire logic loopIsGroupInfo,
  output logic loopReady,
  // descriptor bytes of the announced loop
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  output logic byteReady,
  // reassembled module bytes for the whole-module check
  input wire logic modByteValid,
  input wire logic [7:0] modByteData,
  input wire logic modByteLast,
  // reports
  output ddp_pkg::mod_chain_t modChainOut,
  output ddp_pkg::group_chain_t groupChainOut,
  output ddp_pkg::crc_desc_t crcDescOut,
  output logic crcCheckDone,
  output logic crcCheckMatch
);

  // ==========================================================================
  // parser state
  ddp_pkg::parse_state_t state_r, state_nxt;
  logic inGroupInfo_r;
  logic [7:0] loopRem_r;
  logic [7:0] tag_r;
  logic [7:0] descLen_r;
  logic [7:0] descRem_r;
  logic [7:0] bodyIdx_r;
  logic [7:0] place_r;
  logic [31:0] word_r;
  logic enable_r;
  logic modSeen_r, groupSeen_r, crcSeen_r, crcDone_r, crcMatch_r;
  logic [15:0] descCount_r, skipCount_r;
  logic [31:0] crcExpect_r;
  logic modLastSeen_r;

  // ==========================================================================
  // byte acceptance and descriptor boundaries
  wire loopTake = loopStart && loopReady;
  wire byteTake = byteValid && byteReady;
  wire loopEnds = byteTake && (loopRem_r == 8'h01);
  wire lenIsZero = byteData == 8'h00;
  wire descEndsAtLen = byteTake && (state_r == ddp_pkg::S_LEN) && lenIsZero;
  wire descEndsInBody = byteTake && (state_r == ddp_pkg::S_BODY) && (descRem_r == 8'h01);
  wire descEnds = descEndsAtLen || descEndsInBody;
  wire [7:0] finalLen = (state_r == ddp_pkg::S_LEN) ? byteData : descLen_r;

  // tag recognition depends on which loop carries it
  wire isModChain = !inGroupInfo_r && (tag_r == ddp_pkg::TAG_MODULE_CHAIN);
  wire isWholeCrc = !inGroupInfo_r && (tag_r == ddp_pkg::TAG_WHOLE_CRC);
  wire isGroupChain = inGroupInfo_r && (tag_r == ddp_pkg::TAG_GROUP_CHAIN);
  wire isKnown = isModChain || isWholeCrc || isGroupChain;

  // a short descriptor lacks fields and is dropped like an unknown one
  wire modComplete = isModChain && (finalLen >= ddp_pkg::MOD_CHAIN_BODY_LEN);
  wire crcComplete = isWholeCrc && (finalLen >= ddp_pkg::WHOLE_CRC_BODY_LEN);
  wire groupComplete = isGroupChain && (finalLen >= ddp_pkg::GROUP_CHAIN_BODY_LEN);
  wire reportMod = descEnds && modComplete;
  wire reportCrc = descEnds && crcComplete;
  wire reportGroup = descEnds && groupComplete;
  wire skipDesc = descEnds && !(modComplete || crcComplete || groupComplete);

  // bytes after the last field of a known layout never enter the word
  wire [7:0] lastShiftIdx = isWholeCrc ? 8'h03 : (isModChain ? 8'h02 : 8'h04);
  wire firstShiftIdx = !isWholeCrc;
  wire shiftWord = byteTake && (state_r == ddp_pkg::S_BODY) && isKnown
                   && (bodyIdx_r >= {7'h00, firstShiftIdx}) && (bodyIdx_r <= lastShiftIdx);
  wire [31:0] wordIn = {word_r[23:0], byteData};

  // place decode shared by both chain kinds
  wire [7:0] placeIn = (bodyIdx_r == 8'h00) ? byteData : place_r;
  wire placeIsLast = placeIn == ddp_pkg::PLACE_LAST;
  wire placeIsKnown = (placeIn == ddp_pkg::PLACE_FIRST) || (placeIn == ddp_pkg::PLACE_MIDDLE) || placeIsLast;

  // handshakes: loop taken only when idle, bytes only inside a loop
  assign loopReady = enable_r && (state_r == ddp_pkg::S_IDLE);
  assign byteReady = enable_r && (state_r != ddp_pkg::S_IDLE);

  // ==========================================================================
  // next state; loop end wins over any descriptor still open
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ddp_pkg::S_IDLE: begin
        if (loopTake && (loopLen != 8'h00)) begin
          state_nxt = ddp_pkg::S_TAG;
        end
      end
      ddp_pkg::S_TAG: begin
        if (byteTake) begin
          state_nxt = ddp_pkg::S_LEN;
        end
      end
      ddp_pkg::S_LEN: begin
        if (byteTake) begin
          state_nxt = lenIsZero ? ddp_pkg::S_TAG : ddp_pkg::S_BODY;
        end
      end
      ddp_pkg::S_BODY: begin
        if (descEndsInBody) begin
          state_nxt = ddp_pkg::S_TAG;
        end
      end
    endcase
    if (loopEnds) begin
      state_nxt = ddp_pkg::S_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ddp_pkg::S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // loop context and remaining loop bytes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      inGroupInfo_r <= 1'b0;
      loopRem_r <= 8'h00;
    end else if (loopTake) begin
      inGroupInfo_r <= loopIsGroupInfo;
      loopRem_r <= loopLen;
    end else if (byteTake) begin
      loopRem_r <= loopRem_r - 8'h01;
    end
  end

  // tag, length and body position of the open descriptor
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tag_r <= 8'h00;
      descLen_r <= 8'h00;
      descRem_r <= 8'h00;
      bodyIdx_r <= 8'h00;
    end else if (byteTake) begin
      if (state_r == ddp_pkg::S_TAG) begin
        tag_r <= byteData;
      end
      if (state_r == ddp_pkg::S_LEN) begin
        descLen_r <= byteData;
        descRem_r <= byteData;
        bodyIdx_r <= 8'h00;
      end
      if (state_r == ddp_pkg::S_BODY) begin
        descRem_r <= descRem_r - 8'h01;
        bodyIdx_r <= bodyIdx_r + 8'h01;
      end
    end
  end

  // field capture: first body byte is the place, later field bytes shift into the word, a crc from byte 0
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      place_r <= 8'h00;
      word_r <= 32'h00000000;
    end else begin
      if (byteTake && (state_r == ddp_pkg::S_BODY) && (bodyIdx_r == 8'h00)) begin
        place_r <= byteData;
      end
      if (shiftWord) begin
        word_r <= wordIn;
      end
    end
  end

  // ==========================================================================
  // report pulses; the ident is zeroed when the place says last
  wire [31:0] finalWord = shiftWord ? wordIn : word_r;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      modChainOut <= '0;
      groupChainOut <= '0;
      crcDescOut <= '0;
    end else begin
      modChainOut.valid <= reportMod;
      groupChainOut.valid <= reportGroup;
      crcDescOut.valid <= reportCrc;
      if (reportMod) begin
        modChainOut.place <= placeIn;
        modChainOut.nextValid <= placeIsKnown && !placeIsLast;
        modChainOut.nextModuleIdent <= placeIsLast ? 16'h0000 : finalWord[15:0];
      end
      if (reportGroup) begin
        groupChainOut.place <= placeIn;
        groupChainOut.nextValid <= placeIsKnown && !placeIsLast;
        groupChainOut.nextGroupIdent <= placeIsLast ? 32'h00000000 : finalWord;
      end
      if (reportCrc) begin
        crcDescOut.crc <= finalWord;
      end
    end
  end

  // ==========================================================================
  // whole-module check; runs whether or not section crcs are also in use
  logic [31:0] crcComputed;
  crc32_byte_engine crcEngine (
    .mclk(mclk),
    .rstn(rstn),
    .restart(modLastSeen_r),
    .byteValid(modByteValid),
    .byteData(modByteData),
    .crcValue(crcComputed)
  );

  // compare one cycle after the last byte, once the engine holds its total
  wire crcCompareNow = modLastSeen_r && crcSeen_r;
  wire crcEqual = crcComputed == crcExpect_r;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      modLastSeen_r <= 1'b0;
      crcCheckDone <= 1'b0;
      crcCheckMatch <= 1'b0;
    end else begin
      modLastSeen_r <= modByteValid && modByteLast;
      crcCheckDone <= crcCompareNow;
      if (crcCompareNow) begin
        crcCheckMatch <= crcEqual;
      end
    end
  end

  // ==========================================================================
  // axi4-lite write path: address and data latched independently
  logic awHeld_r, wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  wire doWrite = awHeld_r && wHeld_r && !bvalid;
  wire ctrlWrite = doWrite && (awAddr_r == ddp_pkg::ADDR_CTRL);
  wire clearReq = ctrlWrite && wStrb_r[1] && wData_r[ddp_pkg::CTRL_CLEAR_BIT];

  assign awready = !awHeld_r;
  assign wready = !wHeld_r;
  assign bresp = ddp_pkg::AXI_RESP_OKAY;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      bvalid <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // control and sticky status; a set in the clearing cycle survives
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      enable_r <= ddp_pkg::CTRL_ENABLE_RESET;
      modSeen_r <= 1'b0;
      groupSeen_r <= 1'b0;
      crcSeen_r <= 1'b0;
      crcDone_r <= 1'b0;
      crcMatch_r <= 1'b0;
      crcExpect_r <= 32'h00000000;
      descCount_r <= 16'h0000;
      skipCount_r <= 16'h0000;
    end else begin
      if (ctrlWrite && wStrb_r[0]) begin
        enable_r <= wData_r[ddp_pkg::CTRL_ENABLE_BIT];
      end
      modSeen_r <= reportMod || (modSeen_r && !clearReq);
      groupSeen_r <= reportGroup || (groupSeen_r && !clearReq);
      crcSeen_r <= reportCrc || (crcSeen_r && !clearReq);
      crcDone_r <= crcCompareNow || (crcDone_r && !clearReq);
      if (crcCompareNow) begin
        crcMatch_r <= crcEqual;
      end
      if (reportCrc) begin
        crcExpect_r <= finalWord;
      end
      descCount_r <= clearReq ? {15'h0000, descEnds} : descCount_r + {15'h0000, descEnds};
      skipCount_r <= clearReq ? {15'h0000, skipDesc} : skipCount_r + {15'h0000, skipDesc};
    end
  end

  // ==========================================================================
  // axi4-lite read path; unmapped addresses read zero with okay
  logic [31:0] readMux;
  always_comb begin
    unique case (araddr)
      ddp_pkg::ADDR_CTRL: readMux = {31'h00000000, enable_r};
      ddp_pkg::ADDR_STATUS: readMux = {25'h0000000, crcSeen_r, groupSeen_r, modSeen_r,
                                       crcMatch_r, crcDone_r, state_r};
      ddp_pkg::ADDR_MOD_CHAIN: readMux = {7'h00, modChainOut.nextValid, modChainOut.nextModuleIdent,
                                          modChainOut.place};
      ddp_pkg::ADDR_GROUP_PLACE: readMux = {23'h000000, groupChainOut.nextValid, groupChainOut.place};
      ddp_pkg::ADDR_GROUP_NEXT: readMux = groupChainOut.nextGroupIdent;
      ddp_pkg::ADDR_CRC_EXPECT: readMux = crcExpect_r;
      ddp_pkg::ADDR_CRC_COMPUTED: readMux = crcComputed;
      ddp_pkg::ADDR_COUNTS: readMux = {descCount_r, skipCount_r};
      default: readMux = 32'h00000000;
    endcase
  end

  assign arready = !rvalid;
  assign rresp = ddp_pkg::AXI_RESP_OKAY;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= readMux;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule : download_descriptor_parser
`default_nettype wire

// ===== sim/download_descriptor_parser_props.sv
// port-level checker of the download descriptor parser
`timescale 1ns/1ps
`default_nettype none
module download_descriptor_parser_props (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic loopStart,
  input wire logic [7:0] loopLen,
  input wire logic loopReady,
  input wire logic byteReady,
  input wire logic modByteValid,
  input wire logic modByteLast,
  input wire ddp_pkg::mod_chain_t modChainOut,
  input wire ddp_pkg::group_chain_t groupChainOut,
  input wire logic crcCheckDone,
  input wire logic crcCheckMatch
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ====================
  // loop framing
  property p_loop_zero; loopStart && loopReady && loopLen == 8'h00 |=> loopReady; endproperty
  a_loop_zero: assert property (p_loop_zero) else $error("empty loop busy");
  property p_loop_body; loopStart && loopReady && loopLen != 8'h00 |=> byteReady && !loopReady; endproperty
  a_loop_body: assert property (p_loop_body) else $error("bytes refused");
  // ====================
  // chain reports
  property p_mod_last; modChainOut.valid && modChainOut.place == ddp_pkg::PLACE_LAST
    |-> !modChainOut.nextValid && modChainOut.nextModuleIdent == 16'h0000; endproperty
  a_mod_last: assert property (p_mod_last) else $error("last module ident");
  property p_mod_next; modChainOut.valid && modChainOut.place < ddp_pkg::PLACE_LAST |-> modChainOut.nextValid;
  endproperty
  a_mod_next: assert property (p_mod_next) else $error("module next flag");
  property p_grp_last; groupChainOut.valid && groupChainOut.place == ddp_pkg::PLACE_LAST
    |-> !groupChainOut.nextValid && groupChainOut.nextGroupIdent == 32'h00000000; endproperty
  a_grp_last: assert property (p_grp_last) else $error("last group ident");
  property p_grp_next; groupChainOut.valid && groupChainOut.place < ddp_pkg::PLACE_LAST |-> groupChainOut.nextValid;
  endproperty
  a_grp_next: assert property (p_grp_next) else $error("group next flag");
  // shortest module descriptor is five bytes, so pulses are spaced
  property p_mod_gap; modChainOut.valid |=> !modChainOut.valid [*4]; endproperty
  a_mod_gap: assert property (p_mod_gap) else $error("module reports too close");
  property p_mod_hold; !modChainOut.valid
    |-> $stable({modChainOut.place, modChainOut.nextValid, modChainOut.nextModuleIdent}); endproperty
  a_mod_hold: assert property (p_mod_hold) else $error("module report moved");
  // ====================
  // whole-module check
  property p_done_cause; crcCheckDone |-> $past(modByteValid && modByteLast, 2); endproperty
  a_done_cause: assert property (p_done_cause) else $error("check done without last byte");
  property p_match_hold; !crcCheckDone |-> $stable(crcCheckMatch); endproperty
  a_match_hold: assert property (p_match_hold) else $error("match moved without done");
  c_mod: cover property (modChainOut.valid && modChainOut.place == ddp_pkg::PLACE_LAST);
  c_grp: cover property (groupChainOut.valid && groupChainOut.nextValid);
  c_crc: cover property (crcCheckDone && crcCheckMatch);
endmodule : download_descriptor_parser_props
bind download_descriptor_parser download_descriptor_parser_props i_props (.mclk(mclk), .rstn(rstn),
  .loopStart(loopStart), .loopLen(loopLen), .loopReady(loopReady), .byteReady(byteReady),
  .modByteValid(modByteValid), .modByteLast(modByteLast), .modChainOut(modChainOut),
  .groupChainOut(groupChainOut), .crcCheckDone(crcCheckDone), .crcCheckMatch(crcCheckMatch));
`default_nettype wire

// ===== sim/section_filter_model.sv
// upstream section filter model handing descriptor loops to the parser
`timescale 1ns/1ps
`default_nettype none
module section_filter_model (
  input wire logic mclk,
  output logic loopStart,
  output logic [7:0] loopLen,
  output logic loopIsGroupInfo,
  input wire logic loopReady,
  output logic byteValid,
  output logic [7:0] byteData,
  input wire logic byteReady
);
  logic [7:0] q[$];
  // ====================
  // idle levels at time zero
  initial begin
    loopStart = 1'b0;
    loopLen = 8'h00;
    loopIsGroupInfo = 1'b0;
    byteValid = 1'b0;
    byteData = 8'h00;
  end
  // queued bytes as one loop, gap idle cycles before each byte
  task automatic sendLoop(input logic grp, input int gap);
    loopStart <= 1'b1;
    loopLen <= 8'(q.size());
    loopIsGroupInfo <= grp;
    do @(posedge mclk); while (loopReady !== 1'b1);
    loopStart <= 1'b0;
    loopLen <= 8'(~q.size());
    foreach (q[i]) begin
      // idle data toggles so a stale byte never looks fresh
      repeat (gap) begin
        byteValid <= 1'b0;
        byteData <= ~byteData;
        @(posedge mclk);
      end
      byteValid <= 1'b1;
      byteData <= q[i];
      do @(posedge mclk); while (byteReady !== 1'b1);
    end
    byteValid <= 1'b0;
    byteData <= ~byteData;
    q.delete();
  endtask : sendLoop
endmodule : section_filter_model
`default_nettype wire

// ===== sim/download_descriptor_parser_tb.sv
// self-checking bench of the download descriptor parser
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module download_descriptor_parser_tb;
  logic mclk, rstn, awvalid, wvalid, bready, arvalid, rready, modByteValid, modByteLast;
  logic awready, wready, bvalid, arready, rvalid, loopStart, loopIsGroupInfo, loopReady;
  logic byteValid, byteReady, crcDone, crcMatch, lastMatch;
  logic [7:0] awaddr, araddr, modByteData, loopLen, byteData;
  logic [31:0] wdata, rdata, rd, exp;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  ddp_pkg::mod_chain_t modOut;
  ddp_pkg::group_chain_t grpOut;
  ddp_pkg::crc_desc_t crcOut;
  int mismatches, cmp_count, modCnt, grpCnt, crcHits, p;
  // ====================
  // clock, parts and report counters
  initial begin mclk = 1'b0; forever #5 mclk = ~mclk; end
  download_descriptor_parser i_dut (.mclk(mclk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .loopStart(loopStart), .loopLen(loopLen),
    .loopIsGroupInfo(loopIsGroupInfo), .loopReady(loopReady), .byteValid(byteValid), .byteData(byteData),
    .byteReady(byteReady), .modByteValid(modByteValid), .modByteData(modByteData),
    .modByteLast(modByteLast), .modChainOut(modOut), .groupChainOut(grpOut), .crcDescOut(crcOut),
    .crcCheckDone(crcDone), .crcCheckMatch(crcMatch));
  section_filter_model i_src (.mclk(mclk), .loopStart(loopStart), .loopLen(loopLen),
    .loopIsGroupInfo(loopIsGroupInfo), .loopReady(loopReady), .byteValid(byteValid),
    .byteData(byteData), .byteReady(byteReady));
  always @(posedge mclk) begin
    if (modOut.valid === 1'b1) modCnt++;
    if (grpOut.valid === 1'b1) grpCnt++;
    if (crcDone === 1'b1) begin crcHits++; lastMatch = crcMatch; end
  end
  // ====================
  // bus and stream tasks
  task automatic axWr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1;
    fork
      begin do @(posedge mclk); while (awready !== 1'b1); awvalid <= 1'b0; end
      begin do @(posedge mclk); while (wready !== 1'b1); wvalid <= 1'b0; end
    join
    do @(posedge mclk); while (bvalid !== 1'b1);
    `CHK("bresp", 2'h0, bresp)
  endtask : axWr
  task automatic axRd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a; arvalid <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    `CHK("rresp", 2'h0, rresp)
  endtask : axRd
  // module bytes 1..n, then quiet while the engine restarts
  task automatic sendMod(input int n);
    for (int i = 1; i <= n; i++) begin
      modByteValid <= 1'b1; modByteData <= 8'(i); modByteLast <= (i == n);
      @(posedge mclk);
    end
    modByteValid <= 1'b0; modByteLast <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : sendMod
  function automatic logic [31:0] crcStep(input logic [31:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = (c[31] ^ b[i]) ? {c[30:0], 1'b0} ^ ddp_pkg::CRC_POLY : {c[30:0], 1'b0};
    return c;
  endfunction : crcStep
  task automatic results;
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  initial begin repeat (20000) @(posedge mclk); mismatches++; results(); end
  // ====================
  // tests
  initial begin
    rstn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b1;
    araddr = 8'h00; arvalid = 1'b0; rready = 1'b1; modByteValid = 1'b0; modByteLast = 1'b0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    axRd(ddp_pkg::ADDR_CTRL, rd); `CHK("ctrl", 32'h1, rd)
    axRd(8'h40, rd); `CHK("unmapped", 32'h0, rd)
    for (p = 0; p < 3; p++) begin
      i_src.q = {8'hb4, 8'h03, 8'(p), 8'h12, 8'(8'h30 + p)};
      i_src.sendLoop(1'b0, p);
      i_src.q = {8'hb8, 8'h05, 8'(p), 8'hca, 8'hfe, 8'h00, 8'(p)};
      i_src.sendLoop(1'b1, 0);
      repeat (2) @(posedge mclk);
      `CHK("modPlace", 8'(p), modOut.place)
      `CHK("modNext", p != 2, modOut.nextValid)
      `CHK("modIdent", (p == 2) ? 16'h0 : {8'h12, 8'(8'h30 + p)}, modOut.nextModuleIdent)
      `CHK("grpPlace", 8'(p), grpOut.place)
      `CHK("grpNext", p != 2, grpOut.nextValid)
      `CHK("grpIdent", (p == 2) ? 32'h0 : {24'hcafe00, 8'(p)}, grpOut.nextGroupIdent)
    end
    // odd tags, a misplaced group link and a short module link are skipped
    exp = ddp_pkg::CRC_INIT;
    for (p = 1; p <= 4; p++) exp = crcStep(exp, 8'(p));
    i_src.q = {8'h77, 8'h02, 8'haa, 8'hbb, 8'hb8, 8'h05, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'hb5, 8'h04,
      exp[31:24], exp[23:16], exp[15:8], exp[7:0], 8'hb4, 8'h05, 8'h00, 8'hab, 8'hcd, 8'hee, 8'hee,
      8'hb4, 8'h02, 8'h00, 8'h00};
    i_src.sendLoop(1'b0, 1);
    repeat (2) @(posedge mclk);
    `CHK("crcDesc", exp, crcOut.crc)
    `CHK("modIdentMix", 16'habcd, modOut.nextModuleIdent)
    `CHK("modCnt", 4, modCnt)
    `CHK("grpCnt", 3, grpCnt)
    axRd(ddp_pkg::ADDR_COUNTS, rd); `CHK("counts", 32'h000b0003, rd)
    sendMod(4);
    `CHK("crcHits", 1, crcHits)
    `CHK("crcGood", 1'b1, lastMatch)
    i_src.q = {8'hb5, 8'h04, ~exp[31:24], exp[23:16], exp[15:8], exp[7:0]};
    i_src.sendLoop(1'b0, 0);
    sendMod(4);
    `CHK("crcBad", 1'b0, lastMatch)
    // descriptor cut by the loop end, then an empty loop
    i_src.q = {8'hb4, 8'h03, 8'h00};
    i_src.sendLoop(1'b0, 0);
    i_src.sendLoop(1'b0, 0);
    repeat (2) @(posedge mclk);
    `CHK("cutCnt", 4, modCnt)
    `CHK("emptyLoop", 1'b1, loopReady)
    i_src.q = {8'h77, 8'h01, 8'h00};
    i_src.sendLoop(1'b1, 0);
    repeat (2) @(posedge mclk);
    `CHK("noGroupLink", 3, grpCnt)
    axWr(ddp_pkg::ADDR_CTRL, 32'h0);
    @(posedge mclk);
    `CHK("disabled", 1'b0, loopReady)
    axWr(ddp_pkg::ADDR_CTRL, 32'h101);
    axRd(ddp_pkg::ADDR_COUNTS, rd); `CHK("cleared", 32'h0, rd)
    results();
  end
endmodule : download_descriptor_parser_tb
`default_nettype wire
